// *** aof_top.sv ***
// Output format configuration bank with formatter and output clock phaser.
// Assumes the register port and sample inputs come from logic on CLK.
`timescale 1ns/1ps
`default_nettype none
module aof_top #(
  parameter int DATA_W = 10
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic [DATA_W-1:0] SAMPLE_IN,
  input wire logic SAMPLE_VALID,
  input wire logic PATTERN_ENABLE,
  output logic [DATA_W-1:0] DATA_OUT,
  output logic DATA_VALID,
  output logic BIT_CAPTURE_CLOCK_OUT,
  output logic [3:0] PHASE_STEP
);
  import aof_pkg::*;

  logic [7:0] format_ff, nxt_format;
  logic [7:0] driver_ff, nxt_driver;
  logic [3:0] phase_ff, nxt_phase;
  logic [7:0] pat_lo_ff, nxt_pat_lo;
  logic [7:0] pat_hi_ff, nxt_pat_hi;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [DATA_W-1:0] dout_ff, nxt_dout;
  logic dval_ff, nxt_dval;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [3:0] step_ff, nxt_step;
  logic clk_out_ff, nxt_clk_out;
  logic [15:0] pattern;
  logic [3:0] rel;

  assign pattern = {pat_hi_ff, pat_lo_ff};

  // Other format codes fall back to offset binary
  function automatic logic [DATA_W-1:0] fmt_word(input logic [DATA_W-1:0] w,
                                                 input logic [1:0] sel,
                                                 input logic inv);
    logic [DATA_W-1:0] r;
    r = w;
    if (sel == AOF_FMT_TWOS) begin
      r[DATA_W-1] = ~w[DATA_W-1];
    end
    if (inv) begin
      r = ~r;
    end
    return r;
  endfunction

  function automatic logic [3:0] eff_step(input logic [3:0] code);
    return (code > AOF_PHASE_LAST) ? AOF_PHASE_SAT : code;
  endfunction

  // Register file
  always_comb begin
    nxt_format = format_ff;
    nxt_driver = driver_ff;
    nxt_phase = phase_ff;
    nxt_pat_lo = pat_lo_ff;
    nxt_pat_hi = pat_hi_ff;
    nxt_rdata = rdata_ff;
    if (REG_WR) begin
      unique case (REG_ADDR)
        AOF_ADDR_FORMAT: nxt_format = REG_WDATA & AOF_MASK_FORMAT;
        AOF_ADDR_DRIVER: nxt_driver = REG_WDATA & AOF_MASK_DRIVER;
        AOF_ADDR_PHASE: nxt_phase = REG_WDATA[3:0];
        AOF_ADDR_PAT_LO: nxt_pat_lo = REG_WDATA;
        AOF_ADDR_PAT_HI: nxt_pat_hi = REG_WDATA;
        default: nxt_format = format_ff;
      endcase
    end
    if (REG_RD) begin
      unique case (REG_ADDR)
        AOF_ADDR_FORMAT: nxt_rdata = format_ff;
        AOF_ADDR_DRIVER: nxt_rdata = driver_ff;
        AOF_ADDR_PHASE: nxt_rdata = {4'h0, phase_ff};
        AOF_ADDR_PAT_LO: nxt_rdata = pat_lo_ff;
        AOF_ADDR_PAT_HI: nxt_rdata = pat_hi_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      format_ff <= AOF_RST_FORMAT;
      driver_ff <= AOF_RST_DRIVER;
      phase_ff <= AOF_RST_PHASE;
      pat_lo_ff <= AOF_RST_PAT;
      pat_hi_ff <= AOF_RST_PAT;
      rdata_ff <= 8'h00;
    end else begin
      format_ff <= nxt_format;
      driver_ff <= nxt_driver;
      phase_ff <= nxt_phase;
      pat_lo_ff <= nxt_pat_lo;
      pat_hi_ff <= nxt_pat_hi;
      rdata_ff <= nxt_rdata;
    end
  end

  // Data path never looks at the phase setting
  always_comb begin
    nxt_dval = SAMPLE_VALID;
    nxt_dout = dout_ff;
    if (SAMPLE_VALID) begin
      // Pattern is left-justified: its top bits feed a narrower word
      nxt_dout = fmt_word(PATTERN_ENABLE ? pattern[15 -: DATA_W] : SAMPLE_IN,
                          format_ff[AOF_FMT_LSB +: 2], format_ff[AOF_INV_BIT]);
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      dout_ff <= '0;
      dval_ff <= 1'b0;
    end else begin
      dout_ff <= nxt_dout;
      dval_ff <= nxt_dval;
    end
  end

  // Twelve-step divider; each step is one 60 degree slot
  always_comb begin
    nxt_cnt = (cnt_ff == AOF_PHASE_STEPS - 4'h1) ? 4'h0 : cnt_ff + 4'h1;
    nxt_step = eff_step(phase_ff);
    rel = (cnt_ff >= step_ff) ? cnt_ff - step_ff : cnt_ff + AOF_PHASE_STEPS - step_ff;
    nxt_clk_out = (rel < AOF_PHASE_HALF);
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cnt_ff <= 4'h0;
      step_ff <= AOF_RST_PHASE;
      clk_out_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      step_ff <= nxt_step;
      clk_out_ff <= nxt_clk_out;
    end
  end

  assign REG_RDATA = rdata_ff;
  assign DATA_OUT = dout_ff;
  assign DATA_VALID = dval_ff;
  assign BIT_CAPTURE_CLOCK_OUT = clk_out_ff;
  assign PHASE_STEP = step_ff;

  sequence s_plain_sample(logic [1:0] sel, logic inv);
    SAMPLE_VALID && !PATTERN_ENABLE && format_ff[1:0] == sel && format_ff[AOF_INV_BIT] == inv;
  endsequence

  property p_offset_binary;
    @(posedge CLK) disable iff (SYS_RST)
      s_plain_sample(AOF_FMT_OFFSET, 1'b0) |=> DATA_OUT == $past(SAMPLE_IN);
  endproperty
  a_offset_binary: assert property (p_offset_binary) else $error("offset binary mismatch");

  property p_twos;
    @(posedge CLK) disable iff (SYS_RST)
      s_plain_sample(AOF_FMT_TWOS, 1'b0) |=>
        DATA_OUT == {~$past(SAMPLE_IN[DATA_W-1]), $past(SAMPLE_IN[DATA_W-2:0])};
  endproperty
  a_twos: assert property (p_twos) else $error("twos complement mismatch");

  property p_invert;
    @(posedge CLK) disable iff (SYS_RST)
      s_plain_sample(AOF_FMT_OFFSET, 1'b1) |=> DATA_OUT == ~$past(SAMPLE_IN);
  endproperty
  a_invert: assert property (p_invert) else $error("invert mismatch");

  property p_phase_step;
    @(posedge CLK) disable iff (SYS_RST)
      phase_ff <= AOF_PHASE_LAST |=> PHASE_STEP == $past(phase_ff);
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase step wrong");

  property p_phase_sat;
    @(posedge CLK) disable iff (SYS_RST)
      phase_ff > AOF_PHASE_LAST |=> PHASE_STEP == AOF_PHASE_SAT;
  endproperty
  a_phase_sat: assert property (p_phase_sat) else $error("phase not saturated");

  sequence s_write(logic [7:0] a);
    REG_WR && REG_ADDR == a;
  endsequence

  property p_pat_lo;
    @(posedge CLK) disable iff (SYS_RST)
      s_write(AOF_ADDR_PAT_LO) ##1 !REG_WR ##1 (REG_RD && REG_ADDR == AOF_ADDR_PAT_LO) |=>
        REG_RDATA == $past(REG_WDATA, 3);
  endproperty
  a_pat_lo: assert property (p_pat_lo) else $error("pattern low readback wrong");

  property p_pat_hi;
    @(posedge CLK) disable iff (SYS_RST)
      s_write(AOF_ADDR_PAT_HI) |=> pattern[15:8] == $past(REG_WDATA);
  endproperty
  a_pat_hi: assert property (p_pat_hi) else $error("pattern high not stored");

  property p_latch_indep;
    @(posedge CLK) disable iff (SYS_RST)
      SAMPLE_VALID |=> DATA_VALID;
  endproperty
  a_latch_indep: assert property (p_latch_indep) else $error("valid lost");

  // Idle cycles must neither strobe nor disturb the last word
  property p_hold_idle;
    @(posedge CLK) disable iff (SYS_RST)
      !SAMPLE_VALID |=> !DATA_VALID && DATA_OUT == $past(DATA_OUT);
  endproperty
  a_hold_idle: assert property (p_hold_idle) else $error("idle output changed");

  property p_pattern_fmt;
    @(posedge CLK) disable iff (SYS_RST)
      SAMPLE_VALID && PATTERN_ENABLE && format_ff[1:0] == AOF_FMT_TWOS && !format_ff[AOF_INV_BIT]
        |=> DATA_OUT == {~$past(pattern[15]), $past(pattern[14 -: DATA_W-1])};
  endproperty
  a_pattern_fmt: assert property (p_pattern_fmt) else $error("pattern format wrong");
endmodule
`default_nettype wire

// *** aof_pkg.sv ***
// Constants for the output format configuration bank.
// Assumes one sample clock domain and a register port driven on the same clock.
// Summary of operation
// - Format 00 offset binary, 01 two's complement; invert.
// - Phase code times 60 degrees, reset 0x03.
// - Phase codes 1011 to 1111 give 660 degrees.
// - Pattern low byte register, reset zero.
// - Pattern high byte register; both form sixteen bits.
// - Test pattern follows format and invert settings.
package aof_pkg;
  localparam logic [7:0] AOF_ADDR_FORMAT = 8'h14;
  localparam logic [7:0] AOF_ADDR_DRIVER = 8'h15;
  localparam logic [7:0] AOF_ADDR_PHASE = 8'h16;
  localparam logic [7:0] AOF_ADDR_PAT_LO = 8'h19;
  localparam logic [7:0] AOF_ADDR_PAT_HI = 8'h1A;

  localparam logic [7:0] AOF_RST_FORMAT = 8'h00;
  localparam logic [7:0] AOF_RST_DRIVER = 8'h00;
  localparam logic [3:0] AOF_RST_PHASE = 4'h3;
  localparam logic [7:0] AOF_RST_PAT = 8'h00;

  // Bits kept in each register; the rest read as zero
  localparam logic [7:0] AOF_MASK_FORMAT = 8'h47;
  localparam logic [7:0] AOF_MASK_DRIVER = 8'h30;
  localparam logic [7:0] AOF_MASK_PHASE = 8'h0F;

  localparam int AOF_FMT_LSB = 0;
  localparam int AOF_INV_BIT = 2;
  localparam logic [1:0] AOF_FMT_OFFSET = 2'h0;
  localparam logic [1:0] AOF_FMT_TWOS = 2'h1;

  localparam logic [3:0] AOF_PHASE_LAST = 4'hA;
  localparam logic [3:0] AOF_PHASE_SAT = 4'hB;
  localparam logic [3:0] AOF_PHASE_STEPS = 4'hC;
  localparam logic [3:0] AOF_PHASE_HALF = 4'h6;
  localparam int AOF_DEG_PER_STEP = 60;
endpackage

// *** aof_host.sv ***
// Host model driving the register port of the format bank.
// Assumes the bench owns the clock and calls put and get in turn.
`timescale 1ns/1ps
`default_nettype none
module aof_host (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output var logic wr,
  output var logic rd,
  output var logic [7:0] addr,
  output var logic [7:0] wdata
);
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // Idle bus shows inverted values so a stale address never looks held
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(negedge clk);
    q = rdata;
  endtask
endmodule
`default_nettype wire

// *** adc_output_format_config_bench.sv ***
// Self-checking bench for the output format bank.
// Assumes aof_host as register master and a 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module adc_output_format_config_bench;
  import aof_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wr, rd, sv = 1'b0, pe = 1'b0, dv, bcco;
  logic [7:0] addr, wdata, rdata;
  logic [9:0] sin = 10'h000;
  logic [9:0] dout;
  logic [3:0] step;
  int cyc = 0;
  int n_errors = 0;
  int checks_done = 0;
  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  aof_top aof_top_inst (.CLK(clk), .SYS_RST(sys_rst), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .SAMPLE_IN(sin),
    .SAMPLE_VALID(sv), .PATTERN_ENABLE(pe), .DATA_OUT(dout), .DATA_VALID(dv),
    .BIT_CAPTURE_CLOCK_OUT(bcco), .PHASE_STEP(step));
  aof_host aof_host_inst (.clk(clk), .rdata(rdata), .wr(wr), .rd(rd), .addr(addr),
    .wdata(wdata));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Reset values, then all-ones write to see kept bits; 0x17 is unmapped
  task automatic t_regs;
    logic [7:0] a[6] = '{8'h14, 8'h15, 8'h16, 8'h19, 8'h1A, 8'h17};
    logic [7:0] r[6] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
    logic [7:0] m[6] = '{8'h47, 8'h30, 8'h0F, 8'hFF, 8'hFF, 8'h00};
    logic [7:0] q;
    @(negedge clk);
    chk("step", 16'(step), 16'h3);
    foreach (a[i]) begin
      aof_host_inst.get(a[i], q);
      chk("reset", 16'(q), 16'(r[i]));
      aof_host_inst.put(a[i], 8'hFF);
      aof_host_inst.get(a[i], q);
      chk("readback", 16'(q), 16'(m[i]));
    end
  endtask
  // Step 0 gives the reference wave; later codes must be it delayed
  task automatic t_phase;
    logic [11:0] base;
    int s;
    for (int c = 0; c < 16; c++) begin
      s = (c > 10) ? 11 : c;
      aof_host_inst.put(AOF_ADDR_PHASE, 8'(c));
      repeat (3) @(posedge clk);
      for (int k = 0; k < 12; k++) begin
        @(negedge clk);
        if (c == 0) base[cyc % 12] = bcco;
        else chk("clock", 16'(bcco), 16'(base[(cyc + 12 - s) % 12]));
      end
      if (c == 0) chk("duty", 16'($countones(base)), 16'h6);
      chk("step", 16'(step), 16'(s));
    end
  endtask
  // Phase is left at code 15, so data timing is also seen unchanged by it
  task automatic t_fmt;
    logic [7:0] f[5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h02};
    logic [9:0] e;
    aof_host_inst.put(AOF_ADDR_PAT_LO, 8'hC0);
    aof_host_inst.put(AOF_ADDR_PAT_HI, 8'hA5);
    foreach (f[i]) begin
      aof_host_inst.put(AOF_ADDR_FORMAT, f[i]);
      for (int p = 0; p < 2; p++) begin
        e = p ? 10'h297 : 10'h0F3;
        if (f[i][1:0] == 2'h1) e = e ^ 10'h200;
        if (f[i][2]) e = ~e;
        @(posedge clk);
        pe <= p[0];
        sv <= 1'b1;
        sin <= 10'h0F3;
        @(posedge clk);
        sv <= 1'b0;
        sin <= 10'h30C;
        @(negedge clk);
        chk("valid", 16'(dv), 16'h1);
        chk("data", 16'(dout), 16'(e));
        @(negedge clk);
        chk("valid", 16'(dv), 16'h0);
        chk("hold", 16'(dout), 16'(e));
      end
    end
  endtask
  // Second reset in mid-run must bring back the step, valid, pattern and format reset values
  task automatic t_rst;
    logic [7:0] q;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk("step", 16'(step), 16'h3);
    chk("valid", 16'(dv), 16'h0);
    aof_host_inst.get(AOF_ADDR_PAT_LO, q);
    chk("pattern low", 16'(q), 16'h0);
    aof_host_inst.get(AOF_ADDR_PAT_HI, q);
    chk("pattern high", 16'(q), 16'h0);
    aof_host_inst.get(AOF_ADDR_FORMAT, q);
    chk("format", 16'(q), 16'h0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_phase();
    t_fmt();
    t_rst();
    wrap_up();
  end
  // About five and a half times the expected run
  initial begin
    #80000;
    n_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
